// >>> rtl/cpt_conv_timing.sv
// conversion period timing: divider registers, checks and period counters
//
// Overview of operation
// - reset initialises dividers and control register
// - reset loads A, B 12h, trims 01h
// - reset dividers give 16 kHz at reference
// - synchronous mode takes all timing from transmit
// - divider B below 15 becomes 12h
// - transmit sum 0 or 1 loads plain A
// - receive sum 0 or 1 loads plain A
// - negative transmit sum loads sum plus 40h
// - negative receive sum loads sum plus 40h
// - divider A of 0 or 1 shuts down
// - divider A too small stops serial port
// - converter holds last value when port lost
// - adjust taken during frame sync, current period
// - trim applied near end of period
// - receive trim lands current or next period
// - each command trims one period only
// - code 01 adds trims, 10 subtracts
// - trims six bit, fields 14:9 and 7:2
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cpt_conv_timing #(
  parameter int unsigned MCLK_DIV   = cpt_pkg::MCLK_DIV,
  parameter int unsigned MIN_FS_CYC = cpt_pkg::MIN_FS_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic  [2:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // serial side
  input  wire logic        word_mode_i,
  input  wire logic        transmit_frame_sync_i,
  input  wire logic        dac_load_i,
  input  wire logic [13:0] dac_word_i,
  // converter and timing outputs
  output logic      [13:0] dac_code_o,
  output logic             tx_conv_o,
  output logic             rx_conv_o,
  output logic             serial_enable_o,
  output logic             shutdown_o
);

  typedef struct packed {
    cpt_pkg::cpt_div_t tx;
    cpt_pkg::cpt_div_t rx;
    logic              sync;
    logic              adj_sub;
    cpt_pkg::cpt_adj_t adj_last;
    logic              shut;
    logic              dead;
    logic              close;
    logic              fs_prev;
    logic [10:0]       fs_cnt;
    logic [3:0]        pre;
    logic [13:0]       dac;
    logic [15:0]       rdata;
  } cpt_state_t;

  localparam cpt_pkg::cpt_div_t DIV_RST = '{
    div_a: cpt_pkg::RST_DIV_A,
    trim:  cpt_pkg::RST_TRIM,
    div_b: cpt_pkg::RST_DIV_B};

  // the spacing counter starts saturated so the first sync is never flagged
  localparam cpt_state_t ST_RST = '{
    tx:       DIV_RST,
    rx:       DIV_RST,
    sync:     1'b0,
    adj_sub:  1'b0,
    adj_last: cpt_pkg::CPT_ADJ_NONE,
    shut:     1'b0,
    dead:     1'b0,
    close:    1'b0,
    fs_prev:  1'b0,
    fs_cnt:   11'h7FF,
    pre:      4'h0,
    dac:      14'h0000,
    rdata:    16'h0000};

  cpt_state_t        s_q;
  cpt_state_t        s_d;
  logic              tick;
  logic              live;
  logic              wr_ok;
  logic              arm;
  logic              fs_rise;
  logic [4:0]        a_min;
  logic              clr_close;
  cpt_pkg::cpt_div_t rx_use;
  cpt_pkg::cpt_adj_t adj_cmd;
  logic [5:0]        tx_load;
  logic [5:0]        rx_load;
  logic              tx_pend;
  logic              rx_pend;

  // master clock enable from the system clock
  assign tick     = (s_q.pre == 4'(MCLK_DIV - 1)) && !s_q.shut;
  assign live     = !s_q.shut && !s_q.dead;
  assign wr_ok    = reg_wr_i && live;
  assign adj_cmd  = cpt_pkg::cpt_adj_t'(reg_wdata_i[1:0]);
  assign fs_rise  = transmit_frame_sync_i && !s_q.fs_prev;
  assign a_min    = word_mode_i ? cpt_pkg::A_MIN_WORD : cpt_pkg::A_MIN_BYTE;
  assign clr_close = wr_ok && (reg_addr_i == cpt_pkg::OFS_STATUS)
                     && reg_wdata_i[cpt_pkg::ST_CLOSE];

  assign rx_use = s_q.sync ? s_q.tx : s_q.rx;

  assign arm = wr_ok && (reg_addr_i == cpt_pkg::OFS_ADJ)
               && transmit_frame_sync_i
               && (adj_cmd == cpt_pkg::CPT_ADJ_ADD
                   || adj_cmd == cpt_pkg::CPT_ADJ_SUB);

  always_comb
  begin
    s_d         = s_q;
    s_d.fs_prev = transmit_frame_sync_i;
    s_d.pre     = (s_q.pre == 4'(MCLK_DIV - 1)) ? 4'h0 : s_q.pre + 4'h1;

    // register writes are dropped once the port is lost
    if (wr_ok)
    begin
      unique case (reg_addr_i)
        cpt_pkg::OFS_DIV_A:
        begin
          s_d.tx.div_a = reg_wdata_i[cpt_pkg::TX_LSB +: 5];
          s_d.rx.div_a = reg_wdata_i[cpt_pkg::RX_LSB +: 5];
        end
        cpt_pkg::OFS_TRIM:
        begin
          s_d.tx.trim = reg_wdata_i[cpt_pkg::TX_LSB +: 6];
          s_d.rx.trim = reg_wdata_i[cpt_pkg::RX_LSB +: 6];
        end
        cpt_pkg::OFS_DIV_B:
        begin
          s_d.tx.div_b = cpt_pkg::cpt_fix_b(reg_wdata_i[cpt_pkg::TX_LSB +: 6]);
          s_d.rx.div_b = cpt_pkg::cpt_fix_b(reg_wdata_i[cpt_pkg::RX_LSB +: 6]);
        end
        cpt_pkg::OFS_CTRL:
          s_d.sync = reg_wdata_i[cpt_pkg::CTL_SYNC];
        default:
        begin
        end
      endcase
    end

    if (arm)
    begin
      s_d.adj_sub  = (adj_cmd == cpt_pkg::CPT_ADJ_SUB);
      s_d.adj_last = adj_cmd;
    end

    if (s_q.tx.div_a <= cpt_pkg::A_DEAD_MAX
        || (!s_q.sync && s_q.rx.div_a <= cpt_pkg::A_DEAD_MAX))
      s_d.shut = 1'b1;

    if (s_q.tx.div_a < a_min
        || (!s_q.sync && s_q.rx.div_a < a_min))
      s_d.dead = 1'b1;

    // frame sync spacing watch; a new event beats a clear
    if (clr_close)
      s_d.close = 1'b0;
    if (fs_rise)
    begin
      s_d.fs_cnt = 11'h000;
      if (s_q.fs_cnt < 11'(MIN_FS_CYC))
        s_d.close = 1'b1;
    end
    else if (s_q.fs_cnt != 11'h7FF)
      s_d.fs_cnt = s_q.fs_cnt + 11'h001;

    if (dac_load_i && live)
      s_d.dac = dac_word_i;

    // read data stand in the cycle after the strobe only
    s_d.rdata = 16'h0000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        cpt_pkg::OFS_DIV_A:
          s_d.rdata = {2'b00, s_q.tx.div_a, 2'b00, s_q.rx.div_a, 2'b00};
        cpt_pkg::OFS_TRIM:
          s_d.rdata = {1'b0, s_q.tx.trim, 1'b0, s_q.rx.trim, 2'b00};
        cpt_pkg::OFS_DIV_B:
          s_d.rdata = {1'b0, s_q.tx.div_b, 1'b0, s_q.rx.div_b, 2'b00};
        cpt_pkg::OFS_CTRL:
          s_d.rdata = {15'h0000, s_q.sync};
        cpt_pkg::OFS_ADJ:
          s_d.rdata = {14'h0000, s_q.adj_last};
        cpt_pkg::OFS_STATUS:
          s_d.rdata = {11'h000, rx_pend, tx_pend,
                       s_q.close, s_q.dead, s_q.shut};
        default:
          s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  cpt_trim_calc u_tx_calc (
    .div_a_i (s_q.tx.div_a),
    .trim_i  (s_q.tx.trim),
    .sub_i   (s_q.adj_sub),
    .load_o  (tx_load)
  );

  cpt_trim_calc u_rx_calc (
    .div_a_i (rx_use.div_a),
    .trim_i  (rx_use.trim),
    .sub_i   (s_q.adj_sub),
    .load_o  (rx_load)
  );

  cpt_period_ctr u_tx_ctr (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .arm_i     (arm),
    .div_b_i   (s_q.tx.div_b),
    .a_plain_i ({1'b0, s_q.tx.div_a}),
    .a_trim_i  (tx_load),
    .pend_o    (tx_pend),
    .conv_o    (tx_conv_o)
  );

  cpt_period_ctr u_rx_ctr (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .arm_i     (arm),
    .div_b_i   (rx_use.div_b),
    .a_plain_i ({1'b0, rx_use.div_a}),
    .a_trim_i  (rx_load),
    .pend_o    (rx_pend),
    .conv_o    (rx_conv_o)
  );

  assign reg_rdata_o     = s_q.rdata;
  assign dac_code_o      = s_q.dac;
  assign serial_enable_o = live;
  assign shutdown_o      = s_q.shut;

endmodule : cpt_conv_timing
`default_nettype wire

// >>> rtl/cpt_period_ctr.sv
// two-stage period counter with a one-shot trimmed sub-period
`timescale 1ns/100ps
`default_nettype none
module cpt_period_ctr (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       tick_i,
  input  wire logic       arm_i,
  input  wire logic [5:0] div_b_i,
  input  wire logic [5:0] a_plain_i,
  input  wire logic [5:0] a_trim_i,
  // status
  output logic            pend_o,
  output logic            conv_o
);

  typedef struct packed {
    logic [5:0] a_cnt;
    logic [5:0] b_cnt;
    logic       pend;
    logic       conv;
  } cpt_ctr_st_t;

  localparam cpt_ctr_st_t ST_RST = '{
    a_cnt: 6'h12, b_cnt: 6'h12, pend: 1'b0, conv: 1'b0};

  cpt_ctr_st_t s_q;
  cpt_ctr_st_t s_d;
  logic [5:0]  nb;

  always_comb
  begin
    s_d      = s_q;
    s_d.conv = 1'b0;
    nb       = (s_q.b_cnt <= 6'h01) ? div_b_i : s_q.b_cnt - 6'h01;
    if (tick_i)
    begin
      if (s_q.a_cnt <= 6'h01)
      begin
        s_d.b_cnt = nb;
        s_d.conv  = (s_q.b_cnt <= 6'h01);
        if (nb == 6'h01 && s_q.pend)
        begin
          s_d.a_cnt = a_trim_i;
          s_d.pend  = 1'b0;
        end
        else
          s_d.a_cnt = a_plain_i;
      end
      else
        s_d.a_cnt = s_q.a_cnt - 6'h01;
    end
    if (arm_i)
      s_d.pend = 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  assign pend_o = s_q.pend;
  assign conv_o = s_q.conv;

endmodule : cpt_period_ctr
`default_nettype wire

// >>> rtl/cpt_trim_calc.sv
// counter load value from divider A and signed trim
`timescale 1ns/100ps
`default_nettype none
module cpt_trim_calc (
  // operands
  input  wire logic [4:0] div_a_i,
  input  wire logic [5:0] trim_i,
  input  wire logic       sub_i,
  // result
  output logic      [5:0] load_o
);

  logic [7:0] sum;

  always_comb
  begin
    if (sub_i)
      sum = {3'h0, div_a_i} - {{2{trim_i[5]}}, trim_i};
    else
      sum = {3'h0, div_a_i} + {{2{trim_i[5]}}, trim_i};
    if (sum == 8'h00 || sum == 8'h01)
      load_o = {1'b0, div_a_i};
    else if (sum[7])
      load_o = 6'(sum + cpt_pkg::MOD64_ADD);
    else
      load_o = sum[5:0];
  end

endmodule : cpt_trim_calc
`default_nettype wire

// >>> shared/cpt_pkg.sv
// constants, types and helpers shared by the conversion period timing block
package cpt_pkg;

  // register map, word addresses on the plain register port
  localparam int unsigned     ADDR_W     = 3;
  localparam int unsigned     DATA_W     = 16;
  localparam logic [2:0]      OFS_DIV_A  = 3'h0;
  localparam logic [2:0]      OFS_TRIM   = 3'h1;
  localparam logic [2:0]      OFS_DIV_B  = 3'h2;
  localparam logic [2:0]      OFS_CTRL   = 3'h3;
  localparam logic [2:0]      OFS_ADJ    = 3'h4;
  localparam logic [2:0]      OFS_STATUS = 3'h5;

  // field positions: transmit field high, receive field low
  localparam int unsigned     TX_LSB     = 9;
  localparam int unsigned     RX_LSB     = 2;
  localparam int unsigned     CTL_SYNC   = 0;
  localparam int unsigned     ST_SHUT    = 0;
  localparam int unsigned     ST_DEAD    = 1;
  localparam int unsigned     ST_CLOSE   = 2;
  localparam int unsigned     ST_TXPEND  = 3;
  localparam int unsigned     ST_RXPEND  = 4;

  // reset values and divider limits
  localparam logic [4:0]      RST_DIV_A  = 5'h12;
  localparam logic [5:0]      RST_TRIM   = 6'h01;
  localparam logic [5:0]      RST_DIV_B  = 6'h12;
  localparam logic [5:0]      B_MIN      = 6'h0F;
  localparam logic [5:0]      B_FIX      = 6'h12;
  localparam logic [4:0]      A_MIN_WORD = 5'h04;
  localparam logic [4:0]      A_MIN_BYTE = 5'h05;
  localparam logic [4:0]      A_DEAD_MAX = 5'h01;
  localparam logic [7:0]      MOD64_ADD  = 8'h40;

  // timing: master clock reference and least frame sync spacing
  localparam int unsigned     CLK_HZ     = 40_000_000;
  localparam int unsigned     REF_MCLK_HZ = 10_368_000;
  localparam int unsigned     REF_CONV_HZ = 16_000;
  localparam int unsigned     MCLK_DIV   = 2;
  localparam int unsigned     MIN_FS_HZ  = 25_000;
  localparam int unsigned     MIN_FS_CYC = (CLK_HZ + MIN_FS_HZ - 1) / MIN_FS_HZ;
  localparam int unsigned     FS_CNT_W   = 11;

  // adjust command codes
  typedef enum logic [1:0] {
    CPT_ADJ_NONE = 2'b00,
    CPT_ADJ_ADD  = 2'b01,
    CPT_ADJ_SUB  = 2'b10,
    CPT_ADJ_RSVD = 2'b11
  } cpt_adj_t;

  typedef struct packed {
    logic [4:0] div_a;
    logic [5:0] trim;
    logic [5:0] div_b;
  } cpt_div_t;

  // a divider B below its floor is forced to the fixed value
  function automatic logic [5:0] cpt_fix_b(input logic [5:0] v);
    return (v < B_MIN) ? B_FIX : v;
  endfunction : cpt_fix_b

endpackage : cpt_pkg

// >>> sim/cpt_conv_timing_chk.sv
// port assertions for the conversion period timing block
`timescale 1ns/100ps
`default_nettype none
module cpt_conv_timing_chk #(
  parameter int unsigned MCLK_DIV   = cpt_pkg::MCLK_DIV,
  parameter int unsigned MIN_FS_CYC = cpt_pkg::MIN_FS_CYC
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic  [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        word_mode_i,
  input wire logic        transmit_frame_sync_i,
  input wire logic        dac_load_i,
  input wire logic [13:0] dac_word_i,
  input wire logic [13:0] dac_code_o,
  input wire logic        tx_conv_o,
  input wire logic        rx_conv_o,
  input wire logic        serial_enable_o,
  input wire logic        shutdown_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  rst_clean_a: assert property (!$past(rst_n_i) |-> !shutdown_o && serial_enable_o)
    else $error("port not alive after reset");
  b_fix_a: assert property ((reg_wr_i && serial_enable_o && reg_addr_i == cpt_pkg::OFS_DIV_B
    && reg_wdata_i[14:9] < 6'h0F ##2 reg_rd_i && reg_addr_i == cpt_pkg::OFS_DIV_B)
    |=> reg_rdata_o[14:9] == 6'h12) else $error("small divider b kept");
  shut_set_a: assert property (reg_wr_i && serial_enable_o && reg_addr_i == cpt_pkg::OFS_DIV_A
    && reg_wdata_i[13:9] <= 5'h01 |-> ##2 shutdown_o) else $error("no shutdown on divider a");
  dead_set_a: assert property (reg_wr_i && serial_enable_o && reg_addr_i == cpt_pkg::OFS_DIV_A
    && reg_wdata_i[13:9] < (word_mode_i ? 5'h04 : 5'h05) |-> ##2 !serial_enable_o)
    else $error("port alive with small divider a");
  shut_stay_a: assert property (shutdown_o |=> shutdown_o && !serial_enable_o)
    else $error("shutdown not sticky");
  conv_stop_a: assert property (shutdown_o ##1 shutdown_o |-> !tx_conv_o && !rx_conv_o)
    else $error("conversion while shut");
  dac_hold_a: assert property (!serial_enable_o |=> $stable(dac_code_o))
    else $error("converter word moved while port lost");
  dac_take_a: assert property (dac_load_i && serial_enable_o |=> dac_code_o == $past(dac_word_i))
    else $error("converter word not taken");
  tx_pulse_a: assert property ($rose(tx_conv_o) |=> !tx_conv_o [*3])
    else $error("boundary pulse too long");
endmodule : cpt_conv_timing_chk
bind cpt_conv_timing cpt_conv_timing_chk #(.MCLK_DIV(MCLK_DIV), .MIN_FS_CYC(MIN_FS_CYC)) cpt_chk_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .word_mode_i(word_mode_i),
  .transmit_frame_sync_i(transmit_frame_sync_i), .dac_load_i(dac_load_i), .dac_word_i(dac_word_i),
  .dac_code_o(dac_code_o), .tx_conv_o(tx_conv_o), .rx_conv_o(rx_conv_o),
  .serial_enable_o(serial_enable_o), .shutdown_o(shutdown_o));
`default_nettype wire

// >>> sim/cpt_conv_timing_tb_top.sv
// self-checking bench for the conversion period timing block
`timescale 1ns/100ps
`default_nettype none
module cpt_conv_timing_tb_top;
  localparam int MD = cpt_pkg::MCLK_DIV;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic  [2:0] addr      = 3'h0;
  logic [15:0] wdata     = 16'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        wmode     = 1'b1;
  logic        go        = 1'b0;
  logic [13:0] word      = 14'h0;
  logic        fs;
  logic        load;
  logic [13:0] hword;
  logic [15:0] rdata;
  logic [13:0] dac;
  logic        txc;
  logic        rxc;
  logic        en;
  logic        shut;
  int          fails     = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  cpt_conv_timing #(.MIN_FS_CYC(20)) cpt_conv_timing_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .word_mode_i(wmode), .transmit_frame_sync_i(fs), .dac_load_i(load), .dac_word_i(hword),
    .dac_code_o(dac), .tx_conv_o(txc), .rx_conv_o(rxc), .serial_enable_o(en), .shutdown_o(shut));
  cpt_host_model cpt_host_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go),
    .word_i(word), .fs_o(fs), .load_o(load), .word_o(hword));
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rst;
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask : rst
  task automatic wrr(input logic [2:0] a, input logic [15:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
    // one idle edge so a following write never re-raises the strobe in the same step
    @(posedge clk_sys_i);
  endtask : wrr
  task automatic rdc(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1;
    chk("rdata", e, rdata & m);
    @(posedge clk_sys_i);
  endtask : rdc
  task automatic flags(input logic [1:0] e);
    @(posedge clk_sys_i);
    #1;
    chk("shut and enable", {14'h0, e}, {14'h0, shut, en});
  endtask : flags
  task automatic frame(input logic [13:0] w, input logic [1:0] code);
    go   <= 1'b1;
    word <= w;
    repeat (2) @(posedge clk_sys_i);
    go   <= 1'b0;
    wrr(cpt_pkg::OFS_ADJ, {14'h0, code});
    repeat (9) @(posedge clk_sys_i);
  endtask : frame
  task automatic tick(input logic r, output int t);
    do
    begin
      @(posedge clk_sys_i);
      #1;
    end
    while ((r ? rxc : txc) !== 1'b1);
    t = cyc;
  endtask : tick
  task automatic t_reset;
    int t0;
    int t1;
    rdc(cpt_pkg::OFS_DIV_A, 16'h2448);
    rdc(cpt_pkg::OFS_TRIM, 16'h0204);
    rdc(cpt_pkg::OFS_DIV_B, 16'h2448);
    rdc(cpt_pkg::OFS_CTRL, 16'h0000);
    rdc(3'h6, 16'h0000);
    tick(1'b0, t0);
    tick(1'b0, t1);
    chk("tx period", 16'(18 * 18 * MD), 16'(t1 - t0));
    tick(1'b1, t0);
    tick(1'b1, t1);
    chk("rx period", 16'(18 * 18 * MD), 16'(t1 - t0));
    $display("reset test done");
  endtask : t_reset
  task automatic t_divb;
    wrr(cpt_pkg::OFS_DIV_B, 16'h1C38);
    rdc(cpt_pkg::OFS_DIV_B, 16'h2448);
    wrr(cpt_pkg::OFS_DIV_B, 16'h1E3C);
    rdc(cpt_pkg::OFS_DIV_B, 16'h1E3C);
    $display("divider b test done");
  endtask : t_divb
  task automatic t_adj;
    logic [15:0] tr [7] = '{16'h0204, 16'h0204, 16'h7AF4, 16'h060C, 16'h70E0, 16'h0204, 16'h0204};
    logic [1:0]  cd [7] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b01, 2'b00, 2'b11};
    int          ld [7] = '{5, 3, 4, 4, 60, 4, 4};
    int          t0;
    int          t1;
    int          t2;
    wrr(cpt_pkg::OFS_DIV_A, 16'h0810);
    for (int i = 0; i < 7; i++)
    begin
      wrr(cpt_pkg::OFS_TRIM, tr[i]);
      tick(1'b0, t0);
      frame(14'h0, cd[i]);
      tick(1'b0, t1);
      tick(1'b0, t2);
      chk("trimmed period", 16'((56 + ld[i]) * MD), 16'(t1 - t0));
      chk("next period", 16'(60 * MD), 16'(t2 - t1));
    end
    rdc(cpt_pkg::OFS_STATUS, 16'h0000, 16'h0004);
    rdc(cpt_pkg::OFS_ADJ, 16'h0001);
    $display("adjust test done");
  endtask : t_adj
  task automatic t_close;
    frame(14'h0, 2'b00);
    frame(14'h0, 2'b00);
    rdc(cpt_pkg::OFS_STATUS, 16'h0004, 16'h0004);
    wrr(cpt_pkg::OFS_STATUS, 16'h0004);
    rdc(cpt_pkg::OFS_STATUS, 16'h0000, 16'h0004);
    $display("spacing test done");
  endtask : t_close
  task automatic t_sync;
    int t0;
    int t1;
    rst();
    wrr(cpt_pkg::OFS_CTRL, 16'h0001);
    wrr(cpt_pkg::OFS_DIV_A, 16'h0804);
    tick(1'b1, t0);
    tick(1'b1, t1);
    chk("rx period", 16'(72 * MD), 16'(t1 - t0));
    chk("shutdown", 16'h0000, {15'h0, shut});
    $display("sync test done");
  endtask : t_sync
  task automatic t_shut;
    int k;
    rst();
    frame(14'h1234, 2'b00);
    chk("dac", 16'h1234, {2'h0, dac});
    wrr(cpt_pkg::OFS_DIV_A, 16'h0210);
    flags(2'b10);
    frame(14'h0ABC, 2'b00);
    chk("dac held", 16'h1234, {2'h0, dac});
    rdc(cpt_pkg::OFS_STATUS, 16'h0001, 16'h0001);
    wrr(cpt_pkg::OFS_DIV_A, 16'h2448);
    rdc(cpt_pkg::OFS_DIV_A, 16'h0210);
    k = 0;
    repeat (700)
    begin
      @(posedge clk_sys_i);
      #1;
      k += int'(txc);
    end
    chk("pulses while shut", 16'h0000, 16'(k));
    rst();
    flags(2'b01);
    $display("shutdown test done");
  endtask : t_shut
  task automatic t_dead;
    wmode <= 1'b0;
    wrr(cpt_pkg::OFS_DIV_A, 16'h0810);
    flags(2'b00);
    rst();
    wmode <= 1'b1;
    wrr(cpt_pkg::OFS_DIV_A, 16'h0810);
    flags(2'b01);
    $display("dead port test done");
  endtask : t_dead
  initial
  begin
    rst();
    t_reset();
    t_divb();
    t_adj();
    t_close();
    t_sync();
    t_shut();
    t_dead();
    wrap_up();
  end
endmodule : cpt_conv_timing_tb_top
`default_nettype wire

// >>> sim/cpt_host_model.sv
// host serial port model: frame sync and converter word
`timescale 1ns/100ps
`default_nettype none
module cpt_host_model (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // bench request
  input  wire logic        go_i,
  input  wire logic [13:0] word_i,
  // serial side
  output logic             fs_o,
  output logic             load_o,
  output logic      [13:0] word_o
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 4'h0;
      word_o <= 14'h0;
    end
    else
    begin
      // frame spacing set by bench, frame long enough for a command
      if (go_i)
        cnt_q <= 4'h8;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      // outside the load slot the word toggles so a stale value never matches
      word_o <= (cnt_q == 4'h5) ? word_i : ~word_o;
    end
  end
  assign fs_o   = (cnt_q != 4'h0);
  assign load_o = (cnt_q == 4'h4);
endmodule : cpt_host_model
`default_nettype wire
